/* File: scr_card_model.sv */
// Card side model: free-running card clock and the card I/O line.
// Assumes the bench chooses when each answer character starts.
`timescale 1ns/1ps
`default_nettype none
module scr_card_model #(
  parameter int ETU = 16
) (
  output logic card_clk,
  output logic card_io
);
  initial card_clk = 1'b0;
  initial card_io = 1'b1;
  // Clock runs through answer-to-reset, so it is free running
  always #160 card_clk = ~card_clk;
  // Start is the caller's; normal answers come 400+ cycles after reset rises
  task automatic send(input logic [7:0] d);
    logic [9:0] f;
    f = {^d, d, 1'b0};
    for (int i = 0; i < 10; i++) begin
      card_io = f[i];
      repeat (ETU) @(posedge card_clk);
    end
    // Pull-up brings the line back high once released
    card_io = 1'b1;
  endtask : send
endmodule : scr_card_model
`default_nettype wire

/* File: scr_early_rx.sv */
// Smart card character receiver with early answer detection and receive FIFO.
// Assumes card clock and I/O are asynchronous pins; card reset level comes
// from the activation sequencer on this clock.
// How it works
// - In threshold mode with level seven, full rises when the eighth character is stored.
// - A character arriving at a threshold FIFO holding its whole length sets overrun and replaces the newest entry.
// - With level zero in threshold mode, one stored character raises full.
// - With level zero in threshold mode and one held, a further character sets overrun and overwrites it.
// - Empty is set while nothing unread remains and clear while something does.
// - Threshold behaviour is the same for both character protocols.
// - A start bit at cycles 200 to 336 with reset low sets early answer and is received.
// - A start bit within 336 cycles after reset rises sets early answer and is received.
// - A set early answer drives the active-low interrupt.
// - A start bit in the first 200 cycles with reset low is ignored entirely.
// - A start bit at cycles 368 to 400 is received without early answer.
// - Start detection before the answer window (cycle 400) samples every 46 card clocks.
// - The last 32 cycles of each early window never flag early answer.
// - Both threshold enables fix length eight (one at level zero) and make level the threshold.
// - In threshold mode full and interrupt follow count above level.
`timescale 1ns/1ps
`default_nettype none
module scr_early_rx #(
  parameter int unsigned ETU_CYCLES = scr_pkg::ETU_DEFAULT
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic card_clk,
  input wire logic card_io,
  input wire logic card_reset_pin,
  input wire logic receive_init,
  input wire logic rd_strobe,
  input wire logic threshold_enable_lo,
  input wire logic threshold_enable_hi,
  input wire logic [2:0] fifo_level_field,
  input wire logic overrun_clear,
  input wire logic early_answer_clear,
  output logic [7:0] rd_data,
  output logic buffer_full_flag,
  output logic fifo_empty_flag,
  output logic overrun_flag,
  output logic early_answer_flag,
  output logic int_n
);
  typedef enum logic [1:0] {IDLE, START, BITS, STOP} scr_state_t;

  logic rst_s1, rst_n;
  logic cc_s1, cc_s2, cc_s3, io_s1, io_s2;
  logic rpin_reg;
  logic [15:0] cyc_reg, cyc_next;
  logic [5:0] samp_reg, samp_next;
  scr_state_t state_reg, state_next;
  logic [9:0] etu_reg, etu_next;
  logic [3:0] idx_reg, idx_next;
  logic [7:0] sh_reg, sh_next;
  logic ea_reg, ea_next, int_n_next;
  logic push_reg, push_next;
  logic cc_tick, samp_tick, in_window, early, ignore, look, thr_mode;

  localparam logic [9:0] ETU_FULL = 10'(ETU_CYCLES - 1);
  localparam logic [9:0] ETU_HALF = 10'(ETU_CYCLES / 2);
  // Window end less the uncertainty tail
  localparam logic [15:0] EARLY_CUT = scr_pkg::EARLY_END - scr_pkg::UNCERTAIN_CYC;
  localparam logic [5:0] SAMP_LAST = scr_pkg::SAMPLE_PERIOD - 6'h01;

  // Reset released through two flops; async assert only
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rst_s1 <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_s1 <= 1'b1;
      rst_n <= rst_s1;
    end
  end

  // Pin synchronisers; I/O uses the second stage, clock edges use the second and third
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cc_s1 <= 1'b0;
      cc_s2 <= 1'b0;
      cc_s3 <= 1'b0;
      io_s1 <= 1'b1;
      io_s2 <= 1'b1;
      rpin_reg <= 1'b0;
    end else begin
      cc_s1 <= card_clk;
      cc_s2 <= cc_s1;
      cc_s3 <= cc_s2;
      io_s1 <= card_io;
      io_s2 <= io_s1;
      rpin_reg <= card_reset_pin;
    end
  end

  assign cc_tick = cc_s2 & ~cc_s3;

  always_comb begin
    cyc_next = cyc_reg;
    samp_next = samp_reg;
    if (rpin_reg != card_reset_pin) begin
      cyc_next = scr_pkg::CYC_RESET;
      samp_next = scr_pkg::SAMPLE_RESET;
    end else if (cc_tick) begin
      if (cyc_reg != scr_pkg::CYC_MAX) cyc_next = cyc_reg + 16'h0001;
      if (samp_reg == SAMP_LAST) samp_next = scr_pkg::SAMPLE_RESET;
      else samp_next = samp_reg + 6'h01;
    end
  end

  // Sampler restarts with the counter, so looks fall on cycles 46k-1
  assign samp_tick = cc_tick && samp_reg == SAMP_LAST;
  assign in_window = cyc_reg < scr_pkg::ANSWER_MIN;
  // Window sampled coarsely; card is not expected before 400 anyway
  assign look = in_window ? samp_tick : cc_tick;
  assign ignore = !rpin_reg && cyc_reg < scr_pkg::EARLY_LO_START;
  // Uncertainty tail trimmed from both windows
  assign early = (rpin_reg || cyc_reg >= scr_pkg::EARLY_LO_START)
                 && cyc_reg < EARLY_CUT;

  // Shared by both bit timing states
  function automatic logic [9:0] etu_step(input logic [9:0] v);
    return v + 10'h001;
  endfunction : etu_step

  always_comb begin
    state_next = state_reg;
    etu_next = etu_reg;
    idx_next = idx_reg;
    sh_next = sh_reg;
    push_next = 1'b0;
    ea_next = ea_reg & ~early_answer_clear;
    unique case (state_reg)
      IDLE: begin
        if (look && !io_s2 && !ignore) begin
          if (early) ea_next = 1'b1; // Set wins over clear
          state_next = START;
          etu_next = scr_pkg::ETU_CNT_RESET;
        end
      end
      START: begin
        if (cc_tick) begin
          etu_next = etu_step(etu_reg);
          if (etu_reg == ETU_HALF) begin
            etu_next = scr_pkg::ETU_CNT_RESET;
            idx_next = scr_pkg::BIT_IDX_RESET;
            // Glitch rejection: line back high means no start bit
            state_next = io_s2 ? IDLE : BITS;
          end
        end
      end
      BITS: begin
        if (cc_tick) begin
          etu_next = etu_step(etu_reg);
          if (etu_reg == ETU_FULL) begin
            etu_next = scr_pkg::ETU_CNT_RESET;
            idx_next = idx_reg + 4'h1;
            if (idx_reg < scr_pkg::DATA_BITS) sh_next = {io_s2, sh_reg[7:1]};
            // Parity slot ends the character; parity checks live elsewhere
            if (idx_reg == scr_pkg::DATA_BITS) begin
              push_next = 1'b1; // Early or not, the character is kept
              state_next = STOP;
            end
          end
        end
      end
      STOP: begin
        if (io_s2) state_next = IDLE;
      end
    endcase
    // Early answer and threshold full both pull the interrupt low
    int_n_next = ~(ea_next | (thr_mode & buffer_full_flag));
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cyc_reg <= scr_pkg::CYC_RESET;
      samp_reg <= scr_pkg::SAMPLE_RESET;
      state_reg <= IDLE;
      etu_reg <= scr_pkg::ETU_CNT_RESET;
      idx_reg <= scr_pkg::BIT_IDX_RESET;
      sh_reg <= scr_pkg::DATA_RESET;
      push_reg <= 1'b0;
      ea_reg <= 1'b0;
      int_n <= 1'b1;
    end else begin
      cyc_reg <= cyc_next;
      samp_reg <= samp_next;
      state_reg <= state_next;
      etu_reg <= etu_next;
      idx_reg <= idx_next;
      sh_reg <= sh_next;
      push_reg <= push_next;
      ea_reg <= ea_next;
      int_n <= int_n_next;
    end
  end

  assign early_answer_flag = ea_reg;

  scr_rx_fifo #(
    .DEPTH(scr_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .rst_n(rst_n),
    .init(receive_init),
    .push(push_reg),
    .push_data(sh_reg),
    .pop(rd_strobe),
    .threshold_enable_lo(threshold_enable_lo),
    .threshold_enable_hi(threshold_enable_hi),
    .fifo_level_field(fifo_level_field),
    .overrun_clear(overrun_clear),
    .rd_data(rd_data),
    .buffer_full_flag(buffer_full_flag),
    .fifo_empty_flag(fifo_empty_flag),
    .overrun_flag(overrun_flag),
    .thr_mode(thr_mode)
  );
endmodule : scr_early_rx
`default_nettype wire

/* File: scr_early_rx_sva.sv */
// Checker for the receiver flags, early answer window and interrupt.
// Assumes it is bound to the receiver top and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module scr_early_rx_sva (
  input wire logic clk,
  input wire logic nrst,
  input wire logic card_clk,
  input wire logic card_reset_pin,
  input wire logic rd_strobe,
  input wire logic threshold_enable_lo,
  input wire logic threshold_enable_hi,
  input wire logic [2:0] fifo_level_field,
  input wire logic overrun_clear,
  input wire logic early_answer_clear,
  input wire logic receive_init,
  input wire logic buffer_full_flag,
  input wire logic fifo_empty_flag,
  input wire logic overrun_flag,
  input wire logic early_answer_flag,
  input wire logic int_n
);
  logic [2:0] ck_reg;
  logic pin_reg;
  logic [15:0] cyc_reg;
  wire logic thr = threshold_enable_lo && threshold_enable_hi;
  // Rough card cycle count; a few cycles of slack cover sync delay
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ck_reg <= 3'h0;
      pin_reg <= 1'b0;
      cyc_reg <= 16'h0000;
    end else begin
      ck_reg <= {ck_reg[1:0], card_clk};
      pin_reg <= card_reset_pin;
      if (pin_reg != card_reset_pin) cyc_reg <= 16'h0000;
      else if (ck_reg[1] && !ck_reg[2] && cyc_reg != 16'hffff) cyc_reg <= cyc_reg + 16'h0001;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  sequence s_ea_rise;
    $rose(early_answer_flag);
  endsequence
  sequence s_thr_full;
    (thr && buffer_full_flag) [*2];
  endsequence
  chk_int_on_ea: assert property (s_ea_rise |=> !int_n)
    else $error("int_n not low after early answer");
  chk_ea_window: assert property (s_ea_rise |-> cyc_reg < 16'd342
    && (card_reset_pin || cyc_reg > 16'd195)) else $error("early answer outside window");
  chk_int_idle: assert property ((!early_answer_flag && !thr) [*3] |-> int_n)
    else $error("int_n low with no cause");
  chk_ea_sticky: assert property (early_answer_flag && !early_answer_clear |=> early_answer_flag)
    else $error("early answer lost");
  chk_ovr_sticky: assert property (overrun_flag && !overrun_clear && !receive_init
    |=> overrun_flag) else $error("overrun lost");
  chk_ovr_full: assert property ($rose(overrun_flag) |-> $past(buffer_full_flag))
    else $error("overrun without full");
  chk_empty_full: assert property (fifo_empty_flag |-> !buffer_full_flag)
    else $error("empty and full together");
  chk_full_clears: assert property (thr && fifo_level_field == 3'h7 && buffer_full_flag
    && rd_strobe |-> ##2 !buffer_full_flag) else $error("full stays after read");
  chk_full_lvl0: assert property ($fell(fifo_empty_flag) && thr && fifo_level_field == 3'h0
    |-> buffer_full_flag) else $error("level zero full missing");
  chk_int_thr: assert property (s_thr_full |-> !int_n)
    else $error("int_n high while threshold full");
endmodule : scr_early_rx_sva
bind scr_early_rx scr_early_rx_sva chk_i (.clk, .nrst, .card_clk, .card_reset_pin,
  .rd_strobe, .threshold_enable_lo, .threshold_enable_hi, .fifo_level_field, .overrun_clear,
  .early_answer_clear, .receive_init, .buffer_full_flag, .fifo_empty_flag, .overrun_flag,
  .early_answer_flag, .int_n);
`default_nettype wire

/* File: scr_pkg.sv */
// Shared constants of the smart card receive path: answer timing windows,
// start bit sampling, receive FIFO shape and reset values.
// Assumes all counts are in card clock cycles unless named otherwise.
`default_nettype none
package scr_pkg;
  localparam int unsigned FIFO_DEPTH = 8;
  localparam int unsigned PTR_W = 3;
  localparam int unsigned CNT_W = 4;
  localparam logic [2:0] LEVEL_MAX = 3'h7;
  localparam logic [3:0] COUNT_RESET = 4'h0;
  localparam logic [2:0] PTR_RESET = 3'h0;
  localparam logic [7:0] DATA_RESET = 8'h00;

  localparam int unsigned CYC_W = 16;
  localparam logic [15:0] CYC_RESET = 16'h0000;
  localparam logic [15:0] CYC_MAX = 16'hffff;
  localparam logic [15:0] EARLY_LO_START = 16'd200;
  localparam logic [15:0] EARLY_END = 16'd368;
  localparam logic [15:0] UNCERTAIN_CYC = 16'd32;
  localparam logic [15:0] ANSWER_MIN = 16'd400;
  localparam int unsigned ANSWER_MAX = 40000;

  localparam logic [5:0] SAMPLE_PERIOD = 6'd46;
  localparam logic [5:0] SAMPLE_RESET = 6'h00;
  localparam int unsigned ETU_DEFAULT = 372;
  localparam logic [9:0] ETU_CNT_RESET = 10'h000;
  localparam logic [3:0] BIT_IDX_RESET = 4'h0;
  localparam logic [3:0] DATA_BITS = 4'd8;
endpackage : scr_pkg
`default_nettype wire

/* File: scr_rx_fifo.sv */
// Eight-entry receive FIFO with level-set depth and threshold modes.
// Assumes push and pop are one-cycle pulses from the same clock.
`timescale 1ns/1ps
`default_nettype none
module scr_rx_fifo #(
  parameter int unsigned DEPTH = scr_pkg::FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic init,
  input wire logic push,
  input wire logic [7:0] push_data,
  input wire logic pop,
  input wire logic threshold_enable_lo,
  input wire logic threshold_enable_hi,
  input wire logic [2:0] fifo_level_field,
  input wire logic overrun_clear,
  output logic [7:0] rd_data,
  output logic buffer_full_flag,
  output logic fifo_empty_flag,
  output logic overrun_flag,
  output logic thr_mode
);
  logic [7:0] mem_reg [DEPTH];
  logic [7:0] mem_next [DEPTH];
  logic [2:0] wr_reg, wr_next, rd_reg, rd_next;
  logic [3:0] cnt_reg, cnt_next, depth;
  logic [7:0] rd_data_next;
  logic full_next, empty_next, ovr_next, thr_next, at_cap, do_pop;

  // Same decode serves T=0 and T=1: protocol is not an input here
  always_comb begin
    thr_next = threshold_enable_lo & threshold_enable_hi;
    // Threshold mode forces full length; level 0 keeps one-entry behaviour
    if (thr_next && fifo_level_field != 3'h0) depth = 4'(DEPTH);
    else if (thr_next) depth = 4'h1;
    else depth = {1'b0, fifo_level_field} + 4'h1;
    mem_next = mem_reg;
    wr_next = wr_reg;
    rd_next = rd_reg;
    cnt_next = cnt_reg;
    ovr_next = overrun_flag & ~overrun_clear;
    rd_data_next = rd_data;
    at_cap = (cnt_reg >= depth);
    do_pop = pop && cnt_reg != scr_pkg::COUNT_RESET;
    if (init) begin
      wr_next = scr_pkg::PTR_RESET;
      rd_next = scr_pkg::PTR_RESET;
      cnt_next = scr_pkg::COUNT_RESET;
    end else begin
      if (do_pop) begin
        rd_data_next = mem_reg[rd_reg];
        rd_next = rd_reg + 3'h1;
      end
      if (push && at_cap && !do_pop) begin
        ovr_next = 1'b1;
        // Threshold mode replaces newest entry; plain mode drops the new one
        if (thr_next) mem_next[wr_reg - 3'h1] = push_data;
      end else if (push) begin
        mem_next[wr_reg] = push_data;
        wr_next = wr_reg + 3'h1;
      end
      cnt_next = cnt_reg + ((push && (!at_cap || do_pop)) ? 4'h1 : 4'h0)
                 - (do_pop ? 4'h1 : 4'h0);
    end
    // Full above level in threshold mode, clears when reads bring it down
    if (thr_next) full_next = cnt_next > {1'b0, fifo_level_field};
    else full_next = cnt_next >= depth;
    empty_next = (cnt_next == scr_pkg::COUNT_RESET);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < DEPTH; i++) mem_reg[i] <= scr_pkg::DATA_RESET;
      wr_reg <= scr_pkg::PTR_RESET;
      rd_reg <= scr_pkg::PTR_RESET;
      cnt_reg <= scr_pkg::COUNT_RESET;
      rd_data <= scr_pkg::DATA_RESET;
      buffer_full_flag <= 1'b0;
      fifo_empty_flag <= 1'b1;
      overrun_flag <= 1'b0;
      thr_mode <= 1'b0;
    end else begin
      mem_reg <= mem_next;
      wr_reg <= wr_next;
      rd_reg <= rd_next;
      cnt_reg <= cnt_next;
      rd_data <= rd_data_next;
      buffer_full_flag <= full_next;
      fifo_empty_flag <= empty_next;
      overrun_flag <= ovr_next;
      thr_mode <= thr_next;
    end
  end
endmodule : scr_rx_fifo
`default_nettype wire

/* File: test_scr_early_rx.sv */
// Bench for the receiver: early answer windows and threshold FIFO cases.
// Assumes the card model makes the card clock and the I/O line.
`timescale 1ns/1ps
`default_nettype none
module test_scr_early_rx;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic card_reset_pin = 1'b0;
  logic receive_init = 1'b0;
  logic rd_strobe = 1'b0;
  logic threshold_enable_lo = 1'b0;
  logic threshold_enable_hi = 1'b0;
  logic [2:0] fifo_level_field = 3'h7;
  logic overrun_clear = 1'b0;
  logic early_answer_clear = 1'b0;
  logic card_clk;
  logic card_io;
  logic [7:0] rd_data;
  logic buffer_full_flag;
  logic fifo_empty_flag;
  logic overrun_flag;
  logic early_answer_flag;
  logic int_n;
  int n_fail = 0;
  int checks_done = 0;
  always #20 clk = ~clk;
  scr_card_model #(.ETU(16)) card (.card_clk, .card_io);
  // Short bit time keeps the run brief
  scr_early_rx #(.ETU_CYCLES(16)) DUT (.clk, .nrst, .card_clk, .card_io, .card_reset_pin,
    .receive_init, .rd_strobe, .threshold_enable_lo, .threshold_enable_hi, .fifo_level_field,
    .overrun_clear, .early_answer_clear, .rd_data, .buffer_full_flag, .fifo_empty_flag,
    .overrun_flag, .early_answer_flag, .int_n);
  task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic close_out;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : close_out
  task automatic cc(input int n);
    repeat (n) @(posedge card_clk);
    @(negedge clk);
  endtask : cc
  task automatic pin(input logic v, input int n);
    @(negedge clk) card_reset_pin = v;
    cc(n);
  endtask : pin
  task automatic init(input logic en, input logic [2:0] lv);
    @(negedge clk);
    threshold_enable_lo = en;
    threshold_enable_hi = en;
    fifo_level_field = lv;
    receive_init = 1'b1;
    overrun_clear = 1'b1;
    early_answer_clear = 1'b1;
    repeat (2) @(negedge clk);
    receive_init = 1'b0;
    overrun_clear = 1'b0;
    early_answer_clear = 1'b0;
    repeat (3) @(negedge clk);
  endtask : init
  // Slack covers a start seen up to one 46-cycle look late
  task automatic rx(input logic [7:0] d);
    card.send(d);
    cc(48);
  endtask : rx
  task automatic rd;
    @(negedge clk) rd_strobe = 1'b1;
    @(negedge clk) rd_strobe = 1'b0;
    @(negedge clk);
  endtask : rd
  // Long all-zero frame spans several 46-cycle looks
  task automatic early(input logic lvl, input int dly, input logic ea);
    init(1'b0, 3'h7);
    pin(!lvl, 4);
    pin(lvl, dly);
    rx(8'h00);
    chk("early", early_answer_flag, ea);
    chk("int_n", int_n, !ea);
    chk("empty", fifo_empty_flag, !lvl && dly < 200);
    $display("early %0d %0d done", lvl, dly);
  endtask : early
  task automatic thr8;
    init(1'b1, 3'h7);
    pin(1'b0, 4);
    pin(1'b1, 420);
    for (int i = 0; i < 9; i++) begin
      rx(8'h10 + 8'(i));
      chk("full", buffer_full_flag, i >= 7);
      chk("empty", fifo_empty_flag, 0);
      chk("ovr", overrun_flag, i == 8);
    end
    for (int i = 0; i < 8; i++) begin
      rd;
      chk("data", rd_data, i == 7 ? 8'h18 : 8'h10 + 8'(i));
      chk("full", buffer_full_flag, 0);
    end
    chk("empty", fifo_empty_flag, 1);
    $display("thr8 done");
  endtask : thr8
  task automatic thr3;
    init(1'b1, 3'h3);
    for (int i = 0; i < 5; i++) begin
      rx(8'h30 + 8'(i));
      chk("full", buffer_full_flag, i >= 3);
      chk("int_n", int_n, i < 3);
    end
    chk("ovr", overrun_flag, 0);
    rd;
    chk("full", buffer_full_flag, 1);
    rd;
    chk("full", buffer_full_flag, 0);
    chk("int_n", int_n, 1);
    chk("data", rd_data, 8'h31);
    $display("thr3 done");
  endtask : thr3
  // No protocol select port: one path serves both protocols
  task automatic thr0;
    init(1'b1, 3'h0);
    rx(8'ha5);
    chk("full", buffer_full_flag, 1);
    chk("int_n", int_n, 0);
    rx(8'h5a);
    chk("ovr", overrun_flag, 1);
    rd;
    chk("data", rd_data, 8'h5a);
    chk("empty", fifo_empty_flag, 1);
    chk("int_n", int_n, 1);
    $display("thr0 done");
  endtask : thr0
  initial begin
    repeat (12) @(posedge clk);
    @(negedge clk) nrst = 1'b1;
    repeat (3) @(negedge clk);
    early(1'b0, 20, 1'b0);
    early(1'b0, 210, 1'b1);
    early(1'b0, 340, 1'b0);
    early(1'b0, 370, 1'b0);
    early(1'b1, 100, 1'b1);
    early(1'b1, 370, 1'b0);
    thr8;
    thr3;
    thr0;
    close_out;
  end
  // Tests need about 2.1 ms; 3 ms means a hang
  initial begin
    #3000000;
    n_fail++;
    close_out;
  end
endmodule : test_scr_early_rx
`default_nettype wire
